// File: bench/far_port_model.sv
// Remote transceiver model: sends stream bits, pulls transmit bits
`timescale 1ns/100ps
module far_port_model (
  input  wire logic pclk,
  input  wire logic tx_bit,
  input  wire logic tx_bit_valid,
  output logic      squelch_open_pin,
  output logic      rx_bit,
  output logic      rx_bit_valid,
  output logic      tx_bit_request
);
  initial begin
    squelch_open_pin = 1'h0;
    rx_bit = 1'h0;
    rx_bit_valid = 1'h0;
    tx_bit_request = 1'h0;
  end
  task automatic level(input logic v);
    squelch_open_pin <= v;
  endtask
  // Line flips between strobes so a stale bit never passes
  task automatic send(input int n, input logic first);
    for (int i = 0; i < n; i++) begin
      squelch_open_pin <= 1'h1;
      rx_bit <= first ^ i[0];
      rx_bit_valid <= 1'h1;
      @(posedge pclk);
      rx_bit_valid <= 1'h0;
      rx_bit <= ~rx_bit;
      @(posedge pclk);
    end
  endtask
  task automatic pull(output logic [1:0] got);
    tx_bit_request <= 1'h1;
    @(posedge pclk);
    tx_bit_request <= 1'h0;
    @(posedge pclk);
    got = {tx_bit_valid, tx_bit};
  endtask
endmodule

// File: bench/fsk_bitstream_squelch_logic_tb.sv
// Self-checking bench for the squelch and Bit Stream logic
`timescale 1ns/100ps
module fsk_bitstream_squelch_logic_tb;
  import fsk_squelch_pkg::*;
  localparam int TMO = 20;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        squelch_open_pin, supply_safe_zero_pin, rx_bit, rx_bit_valid;
  logic        tx_bit_request, squelch_mode_cable, channel_busy, tx_bit;
  logic        tx_bit_valid, encoder_bypass, stream_detected, stream_stopped;
  logic [1:0]  got;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          err_total, n_checks, n;
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        err;
  } row_type;
  row_type rows [5] = '{
    '{1'h0, CTRL_OFFSET, 32'h0, CTRL_RESET, 1'h0},
    '{1'h1, CTRL_OFFSET, 32'h5, 32'h0, 1'h0},
    '{1'h0, CTRL_OFFSET, 32'h0, 32'h5, 1'h0},
    '{1'h1, 8'h0c, 32'hf, 32'h0, 1'h1},
    '{1'h0, 8'h0c, 32'h0, 32'h0, 1'h1}};
  fsk_bitstream_squelch_logic #(.TIMEOUT_CYCLES(TMO)) i_dut (.*);
  far_port_model i_far (.*);
  always #20 pclk = ~pclk;
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    // A slave that never answers counts as a mismatch
    if (pready !== 1'h1) err_total++;
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic end_of_test;
    if (err_total == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge pclk);
    err_total++;
    end_of_test;
  end
  initial begin
    pclk = 1'h0;
    presetn = 1'h0;
    {psel, penable, pwrite, supply_safe_zero_pin} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    chk("reset outputs", {channel_busy, encoder_bypass, stream_detected}, 0);
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].addr, rows[i].wdata);
      if (!rows[i].wr) chk("prdata", rd, rows[i].rdata);
      chk("pslverr", er, rows[i].err);
    end
    chk("cable mode", squelch_mode_cable, 32'h1);
    i_far.level(1'h1);
    repeat (8) @(posedge pclk);
    chk("busy in cable mode", channel_busy, 32'h0);
    apb(1'h1, CTRL_OFFSET, 32'h0);
    repeat (2) @(posedge pclk);
    chk("packet mode", squelch_mode_cable, 32'h0);
    chk("busy on open squelch", channel_busy, 32'h1);
    apb(1'h0, STATUS_OFFSET, 32'h0);
    chk("status busy", rd, 32'h1);
    i_far.level(1'h0);
    repeat (8) @(posedge pclk);
    chk("idle on closed squelch", channel_busy, 32'h0);
    // A repeated bit must restart the alternation count
    i_far.send(100, 1'h0);
    i_far.send(127, 1'h1);
    repeat (3) @(posedge pclk);
    chk("detect at 127", stream_detected, 32'h0);
    i_far.send(1, 1'h0);
    repeat (2) @(posedge pclk);
    chk("detect at 128", stream_detected, 32'h1);
    apb(1'h0, COUNT_OFFSET, 32'h0);
    chk("match count", rd, 32'h80);
    i_far.level(1'h0);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (stream_stopped !== 1'h1 && n < TMO + 20);
    chk("stop pulse", stream_stopped, 32'h1);
    chk("stop not early", n >= TMO, 32'h1);
    apb(1'h0, STATUS_OFFSET, 32'h0);
    chk("stop flag", rd[STAT_STOPPED_BIT], 32'h1);
    apb(1'h1, STATUS_OFFSET, 32'h4);
    apb(1'h0, STATUS_OFFSET, 32'h0);
    chk("stop flag clear", rd, 32'h0);
    apb(1'h1, CTRL_OFFSET, 32'h2);
    @(posedge pclk);
    chk("bypass on", encoder_bypass, 32'h1);
    apb(1'h0, STATUS_OFFSET, 32'h0);
    chk("status tx active", rd, 32'h8);
    for (int i = 0; i < 70; i++) begin
      i_far.pull(got);
      chk("tx bit", got, {1'h1, i[0]});
    end
    apb(1'h1, CTRL_OFFSET, 32'h6);
    @(posedge pclk);
    chk("caps ready stop", encoder_bypass, 32'h0);
    i_far.pull(got);
    chk("pull when idle", got[1], 32'h0);
    apb(1'h1, CTRL_OFFSET, 32'h2);
    supply_safe_zero_pin <= 1'h1;
    repeat (10) @(posedge pclk);
    chk("safe zero stop", encoder_bypass, 32'h0);
    apb(1'h0, STATUS_OFFSET, 32'h0);
    chk("status safe zero", rd, 32'h10);
    // Reset in mid-run must clear the sender and the control word
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    chk("mid reset outputs", {channel_busy, encoder_bypass, stream_detected,
        tx_bit, squelch_mode_cable}, 32'h0);
    presetn <= 1'h1;
    apb(1'h0, CTRL_OFFSET, 32'h0);
    chk("ctrl after reset", rd, CTRL_RESET);
    end_of_test;
  end
endmodule

// File: bench/fsk_squelch_sva.sv
// Port checks for the squelch and Bit Stream top
`timescale 1ns/100ps
module fsk_squelch_sva
  import fsk_squelch_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = STREAM_END_CYCLES
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        squelch_open_pin,
  input wire logic        supply_safe_zero_pin,
  input wire logic        rx_bit_valid,
  input wire logic        tx_bit_request,
  input wire logic        squelch_mode_cable,
  input wire logic        channel_busy,
  input wire logic        tx_bit,
  input wire logic        tx_bit_valid,
  input wire logic        encoder_bypass,
  input wire logic        stream_detected,
  input wire logic        stream_stopped
);
  // Raw pin quiet count; the design's sync delay only adds to it
  logic [15:0] quiet;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet <= 16'h0000;
    end else begin
      quiet <= squelch_open_pin ? 16'h0000 : quiet + {15'h0, ~&quiet};
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_ctrl_wr;
    psel && penable && pready && pwrite && paddr == CTRL_OFFSET;
  endsequence
  sequence s_safe_hold;
    supply_safe_zero_pin [*8];
  endsequence
  AST_MODE: assert property (s_ctrl_wr |=>
    squelch_mode_cable == $past(pwdata[CTRL_CABLE_MODE_BIT]))
    else $error("cable mode not taken from write");
  AST_CABLE_QUIET: assert property (
    squelch_mode_cable && $past(squelch_mode_cable) |-> !channel_busy)
    else $error("busy in cable mode");
  AST_BUSY_CAUSE: assert property ($rose(channel_busy) |->
    $past(squelch_open_pin, 5) && !$past(squelch_mode_cable))
    else $error("busy without open squelch");
  AST_TX_TOGGLE: assert property (tx_bit_valid |->
    $past(tx_bit_request) && tx_bit != $past(tx_bit))
    else $error("tx bit not alternating on request");
  AST_CAPS_STOP: assert property (
    s_ctrl_wr ##0 pwdata[CTRL_CAPS_READY_BIT] |-> ##[1:2] !encoder_bypass)
    else $error("stream not stopped by caps ready");
  AST_SAFE_STOP: assert property (s_safe_hold |-> !encoder_bypass)
    else $error("stream sent at safe zero");
  AST_DETECT: assert property (
    $rose(stream_detected) |-> $past(rx_bit_valid, 3))
    else $error("detect not tied to a bit");
  AST_STOP_PULSE: assert property (stream_stopped |->
    $past(stream_detected) && !stream_detected ##1 !stream_stopped)
    else $error("bad stop pulse");
  AST_STOP_QUIET: assert property (
    stream_stopped |-> quiet >= TIMEOUT_CYCLES)
    else $error("stop before quiet timeout");
endmodule

bind fsk_bitstream_squelch_logic fsk_squelch_sva
  #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_sva (.*);

// File: src/fsk_bitstream_squelch_logic.sv
// Top: APB registers, squelch mode, idle detect and Bit Stream sender
`timescale 1ns/100ps
module fsk_bitstream_squelch_logic #(
  parameter int TIMEOUT_CYCLES = fsk_squelch_pkg::STREAM_END_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        squelch_open_pin,
  input  wire logic        supply_safe_zero_pin,
  input  wire logic        rx_bit,
  input  wire logic        rx_bit_valid,
  input  wire logic        tx_bit_request,
  output logic             squelch_mode_cable,
  output logic             channel_busy,
  output logic             tx_bit,
  output logic             tx_bit_valid,
  output logic             encoder_bypass,
  output logic             stream_detected,
  output logic             stream_stopped
);
  import fsk_squelch_pkg::*;

  typedef struct packed {
    logic [SYNC_STAGES-1:0] sq_sync;
    logic [SYNC_STAGES-1:0] sz_sync;
    logic                   sq_level;
    logic                   sz_level;
    logic                   cable_mode;
    logic                   tx_enable;
    logic                   caps_ready;
    logic                   stopped_flag;
    logic                   pready;
    logic                   pslverr;
    logic [31:0]            prdata;
    logic                   busy;
    tx_state_type           tx_state;
    logic                   tx_bit;
    logic                   tx_bit_valid;
    logic [PREAMBLE_W-1:0]  pre_index;
    logic                   mode_out;
    logic                   bypass;
    logic                   detected;
    logic                   stopped;
  } top_state_type;

  top_state_type cur;
  top_state_type next_cur;

  rx_stream_if rx ();

  stream_detector #(
    .TIMEOUT_CYCLES (TIMEOUT_CYCLES)
  ) u_detector (
    .pclk    (pclk),
    .presetn (presetn),
    .rx      (rx.detector)
  );

  assign rx.squelch_open = cur.sq_level;
  assign rx.rx_bit       = rx_bit;
  assign rx.rx_bit_valid = rx_bit_valid;

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == CTRL_OFFSET) || (a == STATUS_OFFSET) ||
                  (a == COUNT_OFFSET);
  endfunction

  function automatic logic [31:0] read_word(input logic [7:0] a,
                                            input top_state_type s,
                                            input logic [MATCH_W-1:0] cnt);
    read_word = 32'h0000_0000;
    if (a == CTRL_OFFSET) begin
      read_word[CTRL_CABLE_MODE_BIT] = s.cable_mode;
      read_word[CTRL_TX_ENABLE_BIT]  = s.tx_enable;
      read_word[CTRL_CAPS_READY_BIT] = s.caps_ready;
    end else if (a == STATUS_OFFSET) begin
      read_word[STAT_BUSY_BIT]      = s.busy;
      read_word[STAT_DETECTED_BIT]  = s.detected;
      read_word[STAT_STOPPED_BIT]   = s.stopped_flag;
      read_word[STAT_TX_ACTIVE_BIT] = (s.tx_state == TX_SEND);
      read_word[STAT_SAFE_ZERO_BIT] = s.sz_level;
    end else if (a == COUNT_OFFSET) begin
      read_word[MATCH_W-1:0] = cnt;
    end
  endfunction

  logic setup_phase;
  logic write_done;
  logic clear_stopped;
  logic tx_stop;

  always_comb begin
    setup_phase   = psel && !penable;
    write_done    = psel && penable && cur.pready && pwrite && !cur.pslverr;
    clear_stopped = write_done && (paddr == STATUS_OFFSET) &&
                    pwdata[STAT_STOPPED_BIT];
    tx_stop       = cur.caps_ready || cur.sz_level;

    next_cur = cur;

    // Pins from the analog side; stage one feeds only stage two
    next_cur.sq_sync = {cur.sq_sync[SYNC_STAGES-2:0], squelch_open_pin};
    next_cur.sz_sync = {cur.sz_sync[SYNC_STAGES-2:0], supply_safe_zero_pin};
    // A level only counts once two stages agree, which also rejects
    // single-cycle spikes that supply ripple can put on the squelch
    if (cur.sq_sync[1] == cur.sq_sync[2]) begin
      next_cur.sq_level = cur.sq_sync[2];
    end
    if (cur.sz_sync[1] == cur.sz_sync[2]) begin
      next_cur.sz_level = cur.sz_sync[2];
    end

    // Zero-wait APB slave: answer in the first access cycle
    next_cur.pready  = setup_phase;
    next_cur.pslverr = setup_phase && !addr_mapped(paddr);
    if (setup_phase) begin
      next_cur.prdata = read_word(paddr, cur, rx.match_count);
    end
    if (write_done && paddr == CTRL_OFFSET) begin
      next_cur.cable_mode = pwdata[CTRL_CABLE_MODE_BIT];
      next_cur.tx_enable  = pwdata[CTRL_TX_ENABLE_BIT];
      next_cur.caps_ready = pwdata[CTRL_CAPS_READY_BIT];
    end

    // Squelch threshold select follows the control register cable-mode bit
    next_cur.mode_out = next_cur.cable_mode;
    // Busy only in packet-watch mode, where the comparator uses the
    // operating threshold; the low threshold would trip on noise
    next_cur.busy = cur.sq_level && !cur.cable_mode;

    // Detector results; set wins over software clear
    next_cur.detected = rx.detected;
    next_cur.stopped  = rx.stopped;
    if (rx.stopped) begin
      next_cur.stopped_flag = 1'b1;
    end else if (clear_stopped) begin
      next_cur.stopped_flag = 1'b0;
    end

    // Bit Stream sender, paced by the modulator's bit request
    next_cur.tx_bit_valid = 1'b0;
    case (cur.tx_state)
      TX_IDLE: begin
        next_cur.bypass = 1'b0;
        if (cur.tx_enable && !tx_stop) begin
          next_cur.tx_state  = TX_SEND;
          next_cur.bypass    = 1'b1;
          next_cur.tx_bit    = 1'b1;
          next_cur.pre_index = '0;
        end
      end
      TX_SEND: begin
        // Ends on any bit; a short final preamble is allowed
        if (tx_stop || !cur.tx_enable) begin
          next_cur.tx_state  = TX_IDLE;
          next_cur.tx_enable = 1'b0;
          next_cur.bypass    = 1'b0;
        end else if (tx_bit_request) begin
          next_cur.tx_bit       = !cur.tx_bit;
          next_cur.tx_bit_valid = 1'b1;
          next_cur.pre_index    = cur.pre_index + PREAMBLE_W'(1);
        end
      end
      default: begin
        next_cur.tx_state = TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '{tx_state: TX_IDLE, default: '0};
    end else begin
      cur <= next_cur;
    end
  end

  assign prdata             = cur.prdata;
  assign pready             = cur.pready;
  assign pslverr            = cur.pslverr;
  assign squelch_mode_cable = cur.mode_out;
  assign channel_busy       = cur.busy;
  assign tx_bit             = cur.tx_bit;
  assign tx_bit_valid       = cur.tx_bit_valid;
  assign encoder_bypass     = cur.bypass;
  assign stream_detected    = cur.detected;
  assign stream_stopped     = cur.stopped;
endmodule

// File: src/fsk_squelch_pkg.sv
// Constants, register map and state types of the squelch and Bit Stream logic
// Notes on behaviour
// - Low-threshold squelch mode during cable-type detection
// - High-threshold squelch mode while watching for packets
// - Channel idle below operating threshold, else busy; busy is held low in cable mode
// - Single-cycle supply spikes on the squelch never raise the busy indication
// - Dead-battery port sends alternating zero-one Bit Stream
// - Last preamble of the stream may be short
// - Send until capabilities ready or supply safe-zero
// - Detected after 128 alternating bits; mismatch restarts
// - Stopped once squelch closed for the timeout
// - Stream bits bypass the 4b5b symbol encoder
package fsk_squelch_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] COUNT_OFFSET  = 8'h08;

  // Control fields
  localparam int CTRL_CABLE_MODE_BIT = 0;
  localparam int CTRL_TX_ENABLE_BIT  = 1;
  localparam int CTRL_CAPS_READY_BIT = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Status fields; stopped flag is write-one-to-clear
  localparam int STAT_BUSY_BIT      = 0;
  localparam int STAT_DETECTED_BIT  = 1;
  localparam int STAT_STOPPED_BIT   = 2;
  localparam int STAT_TX_ACTIVE_BIT = 3;
  localparam int STAT_SAFE_ZERO_BIT = 4;

  // Bit Stream figures
  localparam int PREAMBLE_BITS     = 64;
  localparam int STREAM_MATCH_BITS = 128;
  localparam int MATCH_W           = 8;
  localparam int PREAMBLE_W        = 6;

  // Timing: 25 MHz clock, least stream end timeout rounded up
  localparam int CLOCK_KHZ             = 25000;
  localparam int STREAM_END_TIMEOUT_US = 1000;
  localparam int STREAM_END_CYCLES =
    (STREAM_END_TIMEOUT_US * CLOCK_KHZ + 999) / 1000;
  localparam int TIMER_W = 15;

  localparam int SYNC_STAGES = 3;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } tx_state_type;

  typedef enum logic [1:0] {
    RX_HUNT   = 2'b01,
    RX_LOCKED = 2'b10
  } rx_state_type;

endpackage

// File: src/rx_stream_if.sv
// Signals between the register block and the Bit Stream detector
`timescale 1ns/100ps
interface rx_stream_if;
  import fsk_squelch_pkg::*;

  logic               squelch_open;
  logic               rx_bit;
  logic               rx_bit_valid;
  logic               detected;
  logic               stopped;
  logic [MATCH_W-1:0] match_count;

  modport detector (
    input  squelch_open,
    input  rx_bit,
    input  rx_bit_valid,
    output detected,
    output stopped,
    output match_count
  );

  modport control (
    output squelch_open,
    output rx_bit,
    output rx_bit_valid,
    input  detected,
    input  stopped,
    input  match_count
  );
endinterface

// File: src/stream_detector.sv
// Receive side: Bit Stream match counter and stream end timer
`timescale 1ns/100ps
module stream_detector #(
  parameter int TIMEOUT_CYCLES = fsk_squelch_pkg::STREAM_END_CYCLES
) (
  input  wire logic   pclk,
  input  wire logic   presetn,
  rx_stream_if.detector rx
);
  import fsk_squelch_pkg::*;

  typedef struct packed {
    rx_state_type       state;
    logic               last_bit;
    logic [MATCH_W-1:0] count;
    logic [TIMER_W-1:0] timer;
    logic               detected;
    logic               stopped;
  } det_state_type;

  localparam logic [MATCH_W-1:0] MATCH_TARGET = MATCH_W'(STREAM_MATCH_BITS);
  localparam logic [TIMER_W-1:0] TIMER_LAST   = TIMER_W'(TIMEOUT_CYCLES - 1);

  det_state_type cur;
  det_state_type next_cur;

  always_comb begin
    next_cur = cur;
    next_cur.stopped = 1'b0;
    // Matching continues while locked so a new stream is seen afresh
    if (rx.rx_bit_valid) begin
      next_cur.last_bit = rx.rx_bit;
      if (cur.count != '0 && rx.rx_bit == cur.last_bit) begin
        next_cur.count = MATCH_W'(1);
      end else if (cur.count != MATCH_TARGET) begin
        next_cur.count = cur.count + MATCH_W'(1);
      end
    end
    case (cur.state)
      RX_HUNT: begin
        next_cur.timer = '0;
        if (cur.count == MATCH_TARGET) begin
          next_cur.state    = RX_LOCKED;
          next_cur.detected = 1'b1;
        end
      end
      RX_LOCKED: begin
        // Any opening of the squelch restarts the closed interval
        if (rx.squelch_open) begin
          next_cur.timer = '0;
        end else if (cur.timer == TIMER_LAST) begin
          next_cur.state    = RX_HUNT;
          next_cur.detected = 1'b0;
          next_cur.stopped  = 1'b1;
          next_cur.count    = '0;
          next_cur.timer    = '0;
        end else begin
          next_cur.timer = cur.timer + TIMER_W'(1);
        end
      end
      default: begin
        next_cur.state = RX_HUNT;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '{state: RX_HUNT, default: '0};
    end else begin
      cur <= next_cur;
    end
  end

  assign rx.detected    = cur.detected;
  assign rx.stopped     = cur.stopped;
  assign rx.match_count = cur.count;
endmodule
